/* File: design/bk3_pkg.sv */
package bk3_pkg;

	// ----------------------------------------------------------------
	// Register map
	// ----------------------------------------------------------------
	localparam logic [7:0] BUCK3_CONTROL_ADDR = 8'h18;
	localparam logic [7:0] BUCK3_CONTROL_RESET = 8'h8c;
	localparam int SKIP_BIT = 7;
	localparam int RSVD_BIT = 6;
	localparam int CODE_MSB = 5;
	localparam int CODE_W = 6;

	// ----------------------------------------------------------------
	// Voltage code table, millivolts
	// ----------------------------------------------------------------
	localparam logic [5:0] CODE_FINE_LAST = 6'h1a;
	localparam logic [5:0] CODE_MAX = 6'h3f;
	localparam logic [11:0] MV_FINE_BASE = 12'h384;
	localparam logic [11:0] MV_FINE_STEP = 12'h019;
	localparam logic [11:0] MV_COARSE_BASE = 12'h60e;
	localparam logic [11:0] MV_COARSE_STEP = 12'h032;
	localparam logic [11:0] MV_TOP = 12'hd48;

	// ----------------------------------------------------------------
	// Timing
	// ----------------------------------------------------------------
	localparam int CLK_PERIOD_NS = 10;
	localparam int BLANK_TIME_MS = 5;
	localparam int BLANK_CYCLES = BLANK_TIME_MS * 1000000 / CLK_PERIOD_NS;

	// ----------------------------------------------------------------
	// Types
	// ----------------------------------------------------------------
	typedef enum logic [2:0] {
		ST_HOLD = 3'b001,
		ST_STRAP = 3'b010,
		ST_RUN = 3'b100
	} bk3_state_t;

	typedef struct packed {
		logic wr_en;
		logic rd_en;
		logic [7:0] addr;
		logic [7:0] wdata;
	} bk3_req_t;

	typedef struct packed {
		logic hit;
		logic [7:0] rdata;
	} bk3_rsp_t;

endpackage

/* File: design/bk3_blank_timer.sv */
`timescale 1ns/100ps

module bk3_blank_timer #(
	parameter int unsigned CYCLES = bk3_pkg::BLANK_CYCLES
) (
	input wire logic i_clk,
	input wire logic i_srst,
	input wire logic i_start,
	output logic o_active
);

	localparam int CW = $clog2(CYCLES + 1);

	logic [CW-1:0] cnt;
	logic [CW-1:0] next_cnt;

	// ----------------------------------------------------------------
	// Down counter, retriggered by every start
	// ----------------------------------------------------------------
	always_comb begin
		next_cnt = cnt;
		if (i_start) begin
			next_cnt = CW'(CYCLES);
		end else if (cnt != '0) begin
			next_cnt = cnt - CW'(1);
		end
	end

	always_ff @(posedge i_clk) begin
		if (i_srst) begin
			cnt <= '0;
		end else begin
			cnt <= next_cnt;
		end
	end

	assign o_active = (cnt != '0);

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	blank_load_a: assert property (@(posedge i_clk) disable iff (i_srst)
		i_start |=> (cnt == CW'(CYCLES)) && o_active)
		else $error("blanking count not loaded with full interval");

	blank_end_a: assert property (@(posedge i_clk) disable iff (i_srst)
		(cnt == CW'(1)) && !i_start |=> !o_active)
		else $error("blanking did not end after its interval");

endmodule

/* File: design/bk3_buck3_ctrl.sv */
`timescale 1ns/100ps

// Overview of operation
// - The control register sits at subaddress 0x18 and holds 0x8c after reset.
// - A write takes effect only while the password unlock is granted by the host procedure.
// - Every accepted write blanks over- and under-voltage fault detection of the rail for 5 ms.
// - After reset the default select resistor input may replace the reset value once.
// - Bit 7 enables light-load pulse skipping (1) or forces fixed-frequency PWM (0), reset 1.
// - Bits 5-0 are the voltage code: 0.900 V up in 25 mV to 0x1a, then 50 mV up to 3.400 V.
module bk3_buck3_ctrl #(
	parameter int unsigned BLANK_CYCLES = bk3_pkg::BLANK_CYCLES,
	parameter logic [7:0] ALT_DEFAULT = bk3_pkg::BUCK3_CONTROL_RESET
) (
	input wire logic i_clk,
	input wire logic i_srst,
	input wire bk3_pkg::bk3_req_t i_req,
	input wire logic i_password_unlocked,
	input wire logic i_default_select_resistor,
	input wire logic i_ov_fault_raw,
	input wire logic i_uv_fault_raw,
	output bk3_pkg::bk3_rsp_t o_rsp,
	output logic o_write_taken,
	output logic o_light_load_skip_enable,
	output logic [5:0] o_buck3_voltage_code,
	output logic [11:0] o_voltage_mv,
	output logic o_monitor_blanked,
	output logic o_ov_fault,
	output logic o_uv_fault
);

	bk3_pkg::bk3_state_t state;
	bk3_pkg::bk3_state_t next_state;
	logic skip;
	logic next_skip;
	logic [5:0] code;
	logic [5:0] next_code;
	logic [11:0] next_mv;
	bk3_pkg::bk3_rsp_t next_rsp;
	logic addr_hit;
	logic wr_ok;
	logic blank_active;
	logic next_ov;
	logic next_uv;

	// ----------------------------------------------------------------
	// Access decode
	// ----------------------------------------------------------------
	assign addr_hit = (i_req.addr == bk3_pkg::BUCK3_CONTROL_ADDR);
	assign wr_ok = (state == bk3_pkg::ST_RUN) && i_req.wr_en && addr_hit
		&& i_password_unlocked;
	assign o_write_taken = wr_ok;

	// ----------------------------------------------------------------
	// Register contents and default load
	// ----------------------------------------------------------------
	always_comb begin
		next_state = state;
		next_skip = skip;
		next_code = code;
		case (state)
			bk3_pkg::ST_HOLD: begin
				next_state = bk3_pkg::ST_STRAP;
			end
			bk3_pkg::ST_STRAP: begin
				if (i_default_select_resistor) begin
					next_skip = ALT_DEFAULT[bk3_pkg::SKIP_BIT];
					next_code = ALT_DEFAULT[bk3_pkg::CODE_MSB:0];
				end
				next_state = bk3_pkg::ST_RUN;
			end
			bk3_pkg::ST_RUN: begin
				if (wr_ok) begin
					next_skip = i_req.wdata[bk3_pkg::SKIP_BIT];
					next_code = i_req.wdata[bk3_pkg::CODE_MSB:0];
				end
			end
			default: begin
				next_state = bk3_pkg::ST_HOLD;
			end
		endcase
	end

	always_ff @(posedge i_clk) begin
		if (i_srst) begin
			state <= bk3_pkg::ST_HOLD;
			skip <= bk3_pkg::BUCK3_CONTROL_RESET[bk3_pkg::SKIP_BIT];
			code <= bk3_pkg::BUCK3_CONTROL_RESET[bk3_pkg::CODE_MSB:0];
		end else begin
			state <= next_state;
			skip <= next_skip;
			code <= next_code;
		end
	end

	assign o_light_load_skip_enable = skip;
	assign o_buck3_voltage_code = code;

	// ----------------------------------------------------------------
	// Code to millivolt decode
	// ----------------------------------------------------------------
	always_comb begin
		if (next_code <= bk3_pkg::CODE_FINE_LAST) begin
			next_mv = bk3_pkg::MV_FINE_BASE
				+ ({6'h00, next_code} * bk3_pkg::MV_FINE_STEP);
		end else begin
			next_mv = bk3_pkg::MV_COARSE_BASE
				+ ({6'h00, next_code - bk3_pkg::CODE_FINE_LAST}
				* bk3_pkg::MV_COARSE_STEP);
		end
	end

	// ----------------------------------------------------------------
	// Read port
	// ----------------------------------------------------------------
	always_comb begin
		next_rsp = '0;
		if (i_req.rd_en && addr_hit) begin
			next_rsp.hit = 1'b1;
			next_rsp.rdata = {skip, 1'b0, code};
		end
	end

	// ----------------------------------------------------------------
	// Supervisor blanking
	// ----------------------------------------------------------------
	bk3_blank_timer #(
		.CYCLES(BLANK_CYCLES)
	) u_blank (
		.i_clk(i_clk),
		.i_srst(i_srst),
		.i_start(wr_ok),
		.o_active(blank_active)
	);

	always_comb begin
		next_ov = i_ov_fault_raw && !blank_active;
		next_uv = i_uv_fault_raw && !blank_active;
	end

	always_ff @(posedge i_clk) begin
		if (i_srst) begin
			o_rsp <= '0;
			o_voltage_mv <= bk3_pkg::MV_FINE_BASE
				+ ({6'h00, bk3_pkg::BUCK3_CONTROL_RESET[bk3_pkg::CODE_MSB:0]}
				* bk3_pkg::MV_FINE_STEP);
			o_monitor_blanked <= 1'b0;
			o_ov_fault <= 1'b0;
			o_uv_fault <= 1'b0;
		end else begin
			o_rsp <= next_rsp;
			o_voltage_mv <= next_mv;
			o_monitor_blanked <= blank_active;
			o_ov_fault <= next_ov;
			o_uv_fault <= next_uv;
		end
	end

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	sequence accepted_write_s;
		(state == bk3_pkg::ST_RUN) && i_req.wr_en && addr_hit && i_password_unlocked;
	endsequence

	sequence blanked_run_s;
		blank_active [*8] ##1 o_monitor_blanked;
	endsequence

	reset_value_a: assert property (@(posedge i_clk) disable iff (i_srst)
		(state == bk3_pkg::ST_STRAP) |-> ({skip, 1'b0, code} == 8'h8c))
		else $error("control register not at reset value");

	locked_write_a: assert property (@(posedge i_clk) disable iff (i_srst)
		(state == bk3_pkg::ST_RUN) && i_req.wr_en && !i_password_unlocked
		|-> !o_write_taken ##1 ($stable(skip) && $stable(code)))
		else $error("locked write changed the register");

	write_blanks_a: assert property (@(posedge i_clk) disable iff (i_srst)
		accepted_write_s |=> blanked_run_s ##1 (!o_ov_fault && !o_uv_fault))
		else $error("write did not blank the supervisors");

	strap_load_a: assert property (@(posedge i_clk) disable iff (i_srst)
		(state == bk3_pkg::ST_STRAP) && i_default_select_resistor
		|=> ({skip, 1'b0, code} == {ALT_DEFAULT[7], 1'b0, ALT_DEFAULT[5:0]}))
		else $error("strap default not loaded");

	skip_write_a: assert property (@(posedge i_clk) disable iff (i_srst)
		accepted_write_s |=> (o_light_load_skip_enable == $past(i_req.wdata[7])))
		else $error("skip enable not written");

	code_map_a: assert property (@(posedge i_clk) disable iff (i_srst)
		accepted_write_s ##1 (code == 6'h3f) |-> (o_voltage_mv == 12'hd48))
		else $error("top voltage code not at 3400 mV");

	rsvd_zero_a: assert property (@(posedge i_clk) disable iff (i_srst)
		i_req.rd_en && addr_hit |=> o_rsp.hit && !o_rsp.rdata[6]
		&& (o_rsp.rdata[5:0] == $past(code)))
		else $error("reserved bit read back nonzero");

	// ----------------------------------------------------------------
	// Decode and supervisor checks
	// ----------------------------------------------------------------
	read_miss_a: assert property (@(posedge i_clk) disable iff (i_srst)
		i_req.rd_en && !addr_hit |=> !o_rsp.hit && (o_rsp.rdata == 8'h00))
		else $error("read of another address returned data");

	reset_mv_a: assert property (@(posedge i_clk) disable iff (i_srst)
		(state == bk3_pkg::ST_STRAP) |-> (o_voltage_mv == 12'h4b0))
		else $error("reset voltage not at 1200 mV");

	refused_quiet_a: assert property (@(posedge i_clk) disable iff (i_srst)
		i_req.wr_en && !(addr_hit && i_password_unlocked) && !blank_active
		|=> !blank_active)
		else $error("refused write started blanking");

	fault_mask_a: assert property (@(posedge i_clk) disable iff (i_srst)
		blank_active |=> !o_ov_fault && !o_uv_fault)
		else $error("fault reported during blanking");

	fault_pass_a: assert property (@(posedge i_clk) disable iff (i_srst)
		!blank_active |=> (o_ov_fault == $past(i_ov_fault_raw))
		&& (o_uv_fault == $past(i_uv_fault_raw)))
		else $error("fault not passed outside blanking");

	mv_range_a: assert property (@(posedge i_clk) disable iff (i_srst)
		(o_voltage_mv >= bk3_pkg::MV_FINE_BASE) && (o_voltage_mv <= bk3_pkg::MV_TOP))
		else $error("decoded voltage outside 900 to 3400 mV");

endmodule

/* File: sim/bk3_host.sv */
`timescale 1ns/100ps

module bk3_host (
	input wire logic i_clk,
	input wire bk3_pkg::bk3_rsp_t i_rsp,
	output bk3_pkg::bk3_req_t o_req,
	output logic o_unlocked
);
	initial begin
		o_req = '0;
		o_unlocked = 1'b0;
	end

	task automatic wr(input logic [7:0] addr, input logic [7:0] data, input logic unlock);
		@(posedge i_clk);
		o_unlocked <= unlock;
		o_req.wr_en <= 1'b1;
		o_req.addr <= addr;
		o_req.wdata <= data;
		@(posedge i_clk);
		o_req.wr_en <= 1'b0;
		o_req.wdata <= ~data;
		o_unlocked <= 1'b0;
		#1;
	endtask

	task automatic rd(input logic [7:0] addr, output logic [7:0] data, output logic hit);
		@(posedge i_clk);
		o_req.rd_en <= 1'b1;
		o_req.addr <= addr;
		@(posedge i_clk);
		o_req.rd_en <= 1'b0;
		o_req.addr <= ~addr;
		#1;
		data = i_rsp.rdata;
		hit = i_rsp.hit;
	endtask
endmodule

/* File: sim/tb_bk3_buck3_ctrl.sv */
`timescale 1ns/100ps

module tb_bk3_buck3_ctrl;
	localparam int unsigned BLANK = 20;
	localparam logic [7:0] ALT = 8'h12;
	logic i_clk = 1'b0;
	logic i_srst = 1'b1;
	logic sel = 1'b0;
	logic ov_raw = 1'b0;
	logic uv_raw = 1'b0;
	bk3_pkg::bk3_req_t req;
	bk3_pkg::bk3_rsp_t rsp;
	logic unlocked, taken, skip, blanked, ov, uv;
	logic [5:0] code;
	logic [11:0] mv;
	logic [7:0] d;
	logic h;
	int errors = 0;
	int checked = 0;
	int taken_cnt = 0;

	always #5 i_clk = ~i_clk;

	// Counts write acceptances seen at the sampling edge
	always @(posedge i_clk) begin
		if (taken === 1'b1) begin
			taken_cnt <= taken_cnt + 1;
		end
	end

	bk3_host host_u (.i_clk(i_clk), .i_rsp(rsp), .o_req(req), .o_unlocked(unlocked));

	bk3_buck3_ctrl #(.BLANK_CYCLES(BLANK), .ALT_DEFAULT(ALT)) dut_u (
		.i_clk(i_clk), .i_srst(i_srst), .i_req(req), .i_password_unlocked(unlocked),
		.i_default_select_resistor(sel), .i_ov_fault_raw(ov_raw), .i_uv_fault_raw(uv_raw),
		.o_rsp(rsp), .o_write_taken(taken), .o_light_load_skip_enable(skip),
		.o_buck3_voltage_code(code), .o_voltage_mv(mv), .o_monitor_blanked(blanked),
		.o_ov_fault(ov), .o_uv_fault(uv));

	// ----------------------------------------------------------------
	// Helpers
	// ----------------------------------------------------------------
	task check(input logic [11:0] seen, input logic [11:0] exp);
		checked++;
		if (seen !== exp) begin
			errors++;
			$display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	task results;
		$display("errors %0d checked %0d", errors, checked);
		if (errors == 0 && checked > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask

	function automatic logic [11:0] mv_of(input logic [5:0] c);
		if (c <= 6'h1a) return 12'h384 + 12'h019 * c;
		return 12'h60e + 12'h032 * (c - 6'h1a);
	endfunction

	task wait_clk(input int n);
		repeat (n) @(posedge i_clk);
		#1;
	endtask

	task do_reset(input logic s);
		@(posedge i_clk);
		i_srst <= 1'b1;
		sel <= s;
		repeat (16) @(posedge i_clk);
		i_srst <= 1'b0;
		wait_clk(4);
	endtask

	// ----------------------------------------------------------------
	// Scenarios
	// ----------------------------------------------------------------
	task reset_value;
		host_u.rd(8'h18, d, h);
		check(d, 8'h8c);
		check(h, 1'b1);
		check(skip, 1'b1);
		check(mv, mv_of(6'h0c));
		host_u.rd(8'h17, d, h);
		check({h, d}, 9'h000);
	endtask

	task locked_write;
		host_u.wr(8'h18, 8'h01, 1'b0);
		host_u.wr(8'h17, 8'h01, 1'b1);
		wait_clk(1);
		check(blanked, 1'b0);
		check(12'(taken_cnt), 12'h000);
		host_u.rd(8'h18, d, h);
		check(d, 8'h8c);
	endtask

	task write_blank;
		@(posedge i_clk);
		ov_raw <= 1'b1;
		uv_raw <= 1'b1;
		host_u.wr(8'h18, 8'h7f, 1'b1);
		check({skip, code}, 7'h3f);
		check(mv, 12'hd48);
		check(12'(taken_cnt), 12'h001);
		wait_clk(1);
		check({blanked, ov, uv}, 3'b100);
		wait_clk(BLANK - 1);
		check(blanked, 1'b1);
		wait_clk(1);
		check(blanked, 1'b0);
		wait_clk(2);
		check({ov, uv}, 2'b11);
		@(posedge i_clk);
		ov_raw <= 1'b0;
		uv_raw <= 1'b0;
		host_u.rd(8'h18, d, h);
		check(d, 8'h3f);
	endtask

	task code_table;
		logic [5:0] codes [4];
		codes = '{6'h00, 6'h1a, 6'h1b, 6'h3e};
		for (int i = 0; i < 4; i++) begin
			host_u.wr(8'h18, {2'b11, codes[i]}, 1'b1);
			check(mv, mv_of(codes[i]));
			host_u.rd(8'h18, d, h);
			check(d, {2'b10, codes[i]});
		end
	endtask

	task strap_default;
		do_reset(1'b1);
		host_u.rd(8'h18, d, h);
		check(d, ALT);
		check(mv, mv_of(ALT[5:0]));
		do_reset(1'b0);
		host_u.rd(8'h18, d, h);
		check(d, 8'h8c);
	endtask

	initial begin
		do_reset(1'b0);
		reset_value();
		locked_write();
		write_blank();
		code_table();
		strap_default();
		results();
	end
endmodule
